// ===== temp_readout.sv
// result path of the dual-channel temperature monitor: conversion scheduler,
// averaging, formatting, limit compare, pins and the register file
// assumes the analogue front end answers each measurement start with one result
// pulse on clk, and that register requests arrive on link_clk from the bus engine
module temp_readout #(
   parameter int unsigned FAST_PERIOD = temp_readout_pkg::FAST_PERIOD_CYC
) (
   input  wire logic                            clk,
   input  wire logic                            srst,
   input  wire logic                            ce,
   input  wire temp_readout_pkg::meas_result_s  meas,
   output logic                                 meas_start,
   output logic                                 meas_channel,
   output logic                                 alarm_out_n,
   output logic                                 overtemp_out_n,
   input  wire logic                            link_clk,
   input  wire logic                            link_srst,
   input  wire logic                            req_valid,
   input  wire temp_readout_pkg::reg_req_s      req,
   output logic                                 req_ready,
   output logic                                 rsp_valid,
   output logic [7:0]                           rsp_data
);

   // slowest rate shifts the base period left by 10, which must still fit the 32-bit timer
   if (FAST_PERIOD < 1 || FAST_PERIOD > 32'd4194303) begin : g_period_check
      $error("FAST_PERIOD out of range for 32-bit period timer");
   end

   // ----------------------------------------
   // state of both domains
   // ----------------------------------------
   typedef struct packed {
      temp_readout_pkg::conv_state_e  state;
      logic                           chan;
      logic [31:0]                    timer;
      logic [3:0]                     sample_cnt;
      logic                           avg;
      logic                           fault_seen;
      logic signed [temp_readout_pkg::ACC_W-1:0] acc;
      logic                           meas_start;
      logic [7:0]                     local_val;
      logic [7:0]                     remote_upper;
      logic [7:0]                     remote_frac;
      logic                           remote_fault;
      logic [7:0]                     cfg;
      logic [3:0]                     rate;
      logic [temp_readout_pkg::NUM_LIMITS-1:0][7:0] limit;
      logic [7:0]                     status;
      logic                           alarm_n;
      logic                           overtemp_n;
      logic [1:0]                     req_sync;
      logic                           req_seen;
      logic                           ack_tgl;
      logic [7:0]                     rd_data;
   } core_s;

   typedef struct packed {
      temp_readout_pkg::reg_req_s     held;
      logic                           req_tgl;
      logic [1:0]                     ack_sync;
      logic                           ack_seen;
      logic                           ready;
      logic                           rsp_valid;
      logic [7:0]                     rsp_data;
   } link_s;

   core_s r;
   core_s next_r;
   link_s l;
   link_s next_l;

   // offset and clamp one signed quarter-degree value into upper and fraction bytes
   function automatic logic [15:0] format_result(
      input logic signed [temp_readout_pkg::SAMPLE_W-1:0] q,
      input logic                                         ext
   );
      logic signed [13:0] v;
      logic signed [13:0] top;
      v   = 14'(q);
      top = ext ? temp_readout_pkg::EXT_MAX_Q : temp_readout_pkg::BIN_MAX_Q;
      if (ext)
         v = v + temp_readout_pkg::EXT_OFFSET_Q;
      if (v < 14'sh0000)
         v = 14'sh0000;
      if (v > top)
         v = top;
      return {v[9:2], v[1:0], 6'h00};
   endfunction

   // ----------------------------------------
   // core domain
   // ----------------------------------------
   logic                               ext;
   logic [3:0]                         rate_eff;
   logic [31:0]                        period;
   logic signed [temp_readout_pkg::ACC_W-1:0]    sum;
   logic signed [temp_readout_pkg::SAMPLE_W-1:0] avg_q;
   logic [15:0]                        fmt;
   logic [7:0]                         st;
   logic                               alarm_cond;
   logic                               ot_cond;

   always_comb begin
      next_r     = r;
      ext        = r.cfg[temp_readout_pkg::CFG_RANGE_BIT];
      rate_eff   = (r.rate > temp_readout_pkg::RATE_MAX) ? temp_readout_pkg::RATE_MAX : r.rate;
      period     = 32'(FAST_PERIOD) << (4'd10 - rate_eff);
      sum        = r.acc + temp_readout_pkg::ACC_W'(meas.quarter_deg);
      avg_q      = r.avg ? temp_readout_pkg::SAMPLE_W'(r.acc >>> 4)
                         : temp_readout_pkg::SAMPLE_W'(r.acc);
      fmt        = format_result(avg_q, ext);
      next_r.meas_start = 1'b0;
      if (r.timer != 32'h0000_0000)
         next_r.timer = r.timer - 32'h0000_0001;

      // conversion sequence: local then remote, restarted by the period timer
      unique case (r.state)
         temp_readout_pkg::CONV_WAIT: begin
            if (r.timer == 32'h0000_0000 && !r.cfg[temp_readout_pkg::CFG_STANDBY_BIT]) begin
               next_r.state = temp_readout_pkg::CONV_START;
               next_r.timer = period;
               next_r.chan  = 1'b0;
            end
         end
         temp_readout_pkg::CONV_START: begin
            next_r.meas_start = 1'b1;
            next_r.acc        = '0;
            next_r.sample_cnt = 4'h0;
            next_r.fault_seen = 1'b0;
            next_r.avg        = rate_eff < temp_readout_pkg::RATE_NOAVG_MIN;
            next_r.state      = temp_readout_pkg::CONV_MEAS;
         end
         temp_readout_pkg::CONV_MEAS: begin
            if (meas.valid) begin
               next_r.acc        = sum;
               next_r.fault_seen = r.fault_seen | (r.chan & meas.diode_fault);
               if (!r.avg || r.sample_cnt == temp_readout_pkg::AVG_LAST) begin
                  next_r.state = temp_readout_pkg::CONV_STORE;
               end else begin
                  next_r.sample_cnt = r.sample_cnt + 4'h1;
                  next_r.meas_start = 1'b1;
               end
            end
         end
         temp_readout_pkg::CONV_STORE: begin
            if (!r.chan) begin
               next_r.local_val = fmt[15:8];
               next_r.chan      = 1'b1;
               next_r.state     = temp_readout_pkg::CONV_START;
            end else begin
               next_r.remote_fault = r.fault_seen;
               if (!r.fault_seen) begin
                  next_r.remote_upper = fmt[15:8];
                  next_r.remote_frac  = fmt[7:0];
               end
               next_r.state = temp_readout_pkg::CONV_WAIT;
            end
         end
      endcase

      // limits are compared as raw bytes, so a range change needs new limits from the host
      st = 8'h00;
      st[temp_readout_pkg::ST_LOC_HIGH] = r.local_val > r.limit[temp_readout_pkg::LIM_LOC_HIGH];
      st[temp_readout_pkg::ST_LOC_LOW]  = r.local_val < r.limit[temp_readout_pkg::LIM_LOC_LOW];
      st[temp_readout_pkg::ST_LOC_OT]   = r.local_val > r.limit[temp_readout_pkg::LIM_LOC_OT];
      st[temp_readout_pkg::ST_REM_HIGH] = r.remote_upper > r.limit[temp_readout_pkg::LIM_REM_HIGH];
      st[temp_readout_pkg::ST_REM_LOW]  = r.remote_upper < r.limit[temp_readout_pkg::LIM_REM_LOW];
      st[temp_readout_pkg::ST_REM_OT]   = r.remote_upper > r.limit[temp_readout_pkg::LIM_REM_OT];
      st[temp_readout_pkg::ST_FAULT]    = r.remote_fault;
      next_r.status = st;

      // pins follow the registered status, so they act in standby too
      ot_cond    = r.status[temp_readout_pkg::ST_LOC_OT] | r.status[temp_readout_pkg::ST_REM_OT];
      alarm_cond = r.status[temp_readout_pkg::ST_LOC_HIGH] | r.status[temp_readout_pkg::ST_LOC_LOW]
                 | r.status[temp_readout_pkg::ST_REM_HIGH] | r.status[temp_readout_pkg::ST_REM_LOW]
                 | r.status[temp_readout_pkg::ST_FAULT];
      next_r.overtemp_n = !ot_cond;
      if (r.cfg[temp_readout_pkg::CFG_PINFN_BIT])
         next_r.alarm_n = !ot_cond;
      else
         next_r.alarm_n = !(alarm_cond && !r.cfg[temp_readout_pkg::CFG_MASK_BIT]);

      // register access: request held stable by the link until acknowledged
      next_r.req_sync = {r.req_sync[0], l.req_tgl};
      if (r.req_sync[1] != r.req_seen) begin
         next_r.req_seen = r.req_sync[1];
         next_r.ack_tgl  = !r.ack_tgl;
         next_r.rd_data  = 8'h00;
         if (l.held.write) begin
            if (l.held.addr == temp_readout_pkg::ADDR_CFG_WR)
               next_r.cfg = l.held.data & temp_readout_pkg::CFG_WRITE_MASK;
            else if (l.held.addr == temp_readout_pkg::ADDR_RATE_WR)
               next_r.rate = l.held.data[3:0];
            for (int i = 0; i < temp_readout_pkg::NUM_LIMITS; i++) begin
               if (l.held.addr == temp_readout_pkg::ADDR_LIMIT_BASE + 8'(i))
                  next_r.limit[i] = l.held.data;
            end
         end else begin
            unique case (l.held.addr)
               temp_readout_pkg::ADDR_LOCAL:        next_r.rd_data = r.local_val;
               temp_readout_pkg::ADDR_REMOTE_UPPER: next_r.rd_data = r.remote_upper;
               temp_readout_pkg::ADDR_REMOTE_FRAC:  next_r.rd_data = r.remote_frac;
               temp_readout_pkg::ADDR_STATUS:       next_r.rd_data = r.status;
               temp_readout_pkg::ADDR_CFG_RD:       next_r.rd_data = r.cfg;
               temp_readout_pkg::ADDR_RATE_RD:      next_r.rd_data = {4'h0, r.rate};
               default: begin
                  for (int i = 0; i < temp_readout_pkg::NUM_LIMITS; i++) begin
                     if (l.held.addr == temp_readout_pkg::ADDR_LIMIT_BASE + 8'(i))
                        next_r.rd_data = r.limit[i];
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r       <= '0;
         r.state <= temp_readout_pkg::CONV_WAIT;
         r.cfg   <= temp_readout_pkg::CFG_RESET;
         r.rate  <= temp_readout_pkg::RATE_RESET;
         r.limit[temp_readout_pkg::LIM_LOC_HIGH] <= temp_readout_pkg::LIM_HIGH_RESET;
         r.limit[temp_readout_pkg::LIM_LOC_LOW]  <= temp_readout_pkg::LIM_LOW_RESET;
         r.limit[temp_readout_pkg::LIM_LOC_OT]   <= temp_readout_pkg::LIM_OT_RESET;
         r.limit[temp_readout_pkg::LIM_REM_HIGH] <= temp_readout_pkg::LIM_HIGH_RESET;
         r.limit[temp_readout_pkg::LIM_REM_LOW]  <= temp_readout_pkg::LIM_LOW_RESET;
         r.limit[temp_readout_pkg::LIM_REM_OT]   <= temp_readout_pkg::LIM_OT_RESET;
         r.alarm_n    <= 1'b1;
         r.overtemp_n <= 1'b1;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign meas_start     = r.meas_start;
   assign meas_channel   = r.chan;
   assign alarm_out_n    = r.alarm_n;
   assign overtemp_out_n = r.overtemp_n;

   // ----------------------------------------
   // link domain: toggle handshake toward the core
   // ----------------------------------------
   always_comb begin
      next_l           = l;
      next_l.rsp_valid = 1'b0;
      next_l.ack_sync  = {l.ack_sync[0], r.ack_tgl};
      if (req_valid && l.ready) begin
         next_l.held    = req;
         next_l.req_tgl = !l.req_tgl;
         next_l.ready   = 1'b0;
      end
      if (l.ack_sync[1] != l.ack_seen) begin
         next_l.ack_seen  = l.ack_sync[1];
         next_l.rsp_data  = r.rd_data;  // held stable since the ack toggled
         next_l.rsp_valid = !l.held.write;
         next_l.ready     = 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         l       <= '0;
         l.ready <= 1'b1;
      end else begin
         l <= next_l;
      end
   end

   assign req_ready = l.ready;
   assign rsp_valid = l.rsp_valid;
   assign rsp_data  = l.rsp_data;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_local_then_remote: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_STORE && !r.chan)
      |=> (r.state == temp_readout_pkg::CONV_START && r.chan))
      else $error("remote conversion did not follow local");
   a_status_follows: assert property (@(posedge clk) disable iff (srst || !ce)
      1'b1 |=> r.status[temp_readout_pkg::ST_REM_HIGH]
               == $past(r.remote_upper > r.limit[temp_readout_pkg::LIM_REM_HIGH]))
      else $error("remote high flag wrong");
   a_overtemp_pin: assert property (@(posedge clk) disable iff (srst || !ce)
      r.status[temp_readout_pkg::ST_LOC_OT] |=> !overtemp_out_n)
      else $error("overtemp output not asserted");
   a_alarm_second_ot: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.cfg[temp_readout_pkg::CFG_PINFN_BIT] && r.status[temp_readout_pkg::ST_REM_OT])
      |=> !alarm_out_n)
      else $error("alarm pin not acting as second overtemp");
   a_alarm_fault: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.status[temp_readout_pkg::ST_FAULT] && r.cfg[7:5] == 3'b000) |=> !alarm_out_n)
      else $error("alarm not asserted on diode fault");
   a_frac_low_zero: assert property (@(posedge clk) disable iff (srst || !ce)
      r.remote_frac[5:0] == 6'h00)
      else $error("remote fraction low bits nonzero");
   a_remote_pair: assert property (@(posedge clk) disable iff (srst || !ce)
      $changed(r.remote_frac) |-> $past(r.state) == temp_readout_pkg::CONV_STORE && $past(r.chan))
      else $error("remote fraction updated outside remote store");
   a_fault_holds: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_STORE && r.chan && r.fault_seen) |=> $stable(r.remote_upper))
      else $error("remote result overwritten on diode fault");
   a_binary_clamp: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_STORE && !r.chan && !ext) |=> r.local_val <= 8'h7f)
      else $error("binary local result above 127");
   a_standby_hold: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_WAIT && r.cfg[temp_readout_pkg::CFG_STANDBY_BIT])
      |=> r.state == temp_readout_pkg::CONV_WAIT)
      else $error("conversion started in standby");
   a_fast_no_avg: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_START && r.rate >= temp_readout_pkg::RATE_NOAVG_MIN)
      |=> !r.avg)
      else $error("averaging at fast rate");
   a_link_accept: assert property (@(posedge link_clk) disable iff (link_srst)
      (req_valid && req_ready) |=> !req_ready ##1 !req_ready)
      else $error("link ready while request outstanding");
   a_remote_ot_pin: assert property (@(posedge clk) disable iff (srst || !ce)
      r.status[temp_readout_pkg::ST_REM_OT] |=> !overtemp_out_n)
      else $error("overtemp output not asserted for remote");
   a_alarm_high: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.status[temp_readout_pkg::ST_REM_HIGH] && !r.cfg[temp_readout_pkg::CFG_PINFN_BIT]
       && !r.cfg[temp_readout_pkg::CFG_MASK_BIT]) |=> !alarm_out_n)
      else $error("alarm not asserted on high limit");
   a_alarm_masked: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.cfg[temp_readout_pkg::CFG_MASK_BIT] && !r.cfg[temp_readout_pkg::CFG_PINFN_BIT])
      |=> alarm_out_n)
      else $error("masked alarm output driven low");
   a_slow_avg: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.state == temp_readout_pkg::CONV_START && r.rate < temp_readout_pkg::RATE_NOAVG_MIN)
      |=> r.avg)
      else $error("no averaging at slow rate");
   a_cfg_reserved: assert property (@(posedge clk) disable iff (srst || !ce)
      (r.cfg & ~temp_readout_pkg::CFG_WRITE_MASK) == 8'h00)
      else $error("reserved configuration bit set");
   a_link_answer: assert property (@(posedge link_clk) disable iff (link_srst)
      (req_valid && req_ready) |=> ##[1:5] req_ready)
      else $error("link request not answered in time");
   a_rsp_reads_only: assert property (@(posedge link_clk) disable iff (link_srst)
      rsp_valid |-> !l.held.write)
      else $error("response given for a write");

endmodule // temp_readout

// ===== temp_readout_pkg.sv
// constants, types and register map of the dual-channel temperature result readout
// assumes a single core clock of 100 MHz and a register link on its own clock
//
// Notes on behaviour
// - free-running conversions alternate local then remote
// - compare results to high, low, overtemp limits
// - alarm low on high, low or diode fault
// - overtemp output low above overtemp limit
// - alarm pin may act as second overtemp
// - limit and control writable, all registers readable
// - standby, range, mask, pin function, rate settings
// - average 16 below 16/s, none otherwise
// - local result whole degrees at 0x00
// - remote upper 0x01, fraction 0x10
// - fraction top two bits, quarter degrees
// - remote bytes not locked; host reads quickly
// - config bit 2 selects extended range
// - new range applies from next stored result
// - extended registers span -64 to 191
// - shorted diode keeps last good remote
// - binary default, offset-by-64 in extended
// - binary clamps below 0 and above 127
// - range change leaves limits untouched
// - config read 0x03, written 0x09
package temp_readout_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_LOCAL        = 8'h00;
   localparam logic [7:0] ADDR_REMOTE_UPPER = 8'h01;
   localparam logic [7:0] ADDR_STATUS       = 8'h02;
   localparam logic [7:0] ADDR_CFG_RD       = 8'h03;
   localparam logic [7:0] ADDR_RATE_RD      = 8'h04;
   localparam logic [7:0] ADDR_CFG_WR       = 8'h09;
   localparam logic [7:0] ADDR_RATE_WR      = 8'h0a;
   localparam logic [7:0] ADDR_REMOTE_FRAC  = 8'h10;
   localparam logic [7:0] ADDR_LIMIT_BASE   = 8'h20;
   localparam int         NUM_LIMITS        = 6;
   // limit index order: local high, low, overtemp, remote high, low, overtemp
   localparam int         LIM_LOC_HIGH      = 0;
   localparam int         LIM_LOC_LOW       = 1;
   localparam int         LIM_LOC_OT        = 2;
   localparam int         LIM_REM_HIGH      = 3;
   localparam int         LIM_REM_LOW       = 4;
   localparam int         LIM_REM_OT        = 5;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int         CFG_RANGE_BIT     = 2;
   localparam int         CFG_PINFN_BIT     = 5;
   localparam int         CFG_STANDBY_BIT   = 6;
   localparam int         CFG_MASK_BIT      = 7;
   localparam logic [7:0] CFG_WRITE_MASK    = 8'he4;
   localparam logic [7:0] CFG_RESET         = 8'h00;
   localparam logic [3:0] RATE_RESET        = 4'h8;
   localparam logic [3:0] RATE_MAX          = 4'ha;
   localparam logic [3:0] RATE_NOAVG_MIN    = 4'h8;
   localparam logic [7:0] LIM_HIGH_RESET    = 8'h7f;
   localparam logic [7:0] LIM_LOW_RESET     = 8'h00;
   localparam logic [7:0] LIM_OT_RESET      = 8'h7f;
   localparam int         ST_LOC_HIGH       = 6;
   localparam int         ST_LOC_LOW        = 5;
   localparam int         ST_REM_HIGH       = 4;
   localparam int         ST_REM_LOW        = 3;
   localparam int         ST_FAULT          = 2;
   localparam int         ST_REM_OT         = 1;
   localparam int         ST_LOC_OT         = 0;

   // ----------------------------------------
   // result format and timing
   // ----------------------------------------
   localparam int                 SAMPLE_W        = 12;  // signed quarter degrees
   localparam int                 ACC_W           = 16;
   localparam logic [3:0]         AVG_LAST        = 4'hf;
   localparam logic signed [13:0] EXT_OFFSET_Q    = 14'sh0100;
   localparam logic signed [13:0] BIN_MAX_Q       = 14'sh01fc;
   localparam logic signed [13:0] EXT_MAX_Q       = 14'sh03ff;
   localparam int                 CLK_MHZ         = 100;
   localparam int                 FAST_PERIOD_US  = 15625;  // 64 conversions/s
   localparam int                 FAST_PERIOD_CYC = FAST_PERIOD_US * CLK_MHZ;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CONV_WAIT  = 2'b00,
      CONV_START = 2'b01,
      CONV_MEAS  = 2'b10,
      CONV_STORE = 2'b11
   } conv_state_e;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_s;

   typedef struct packed {
      logic                       valid;
      logic                       diode_fault;
      logic signed [SAMPLE_W-1:0] quarter_deg;
   } meas_result_s;

endpackage

// ===== fe_model.sv
// analogue front end model: answers every meas_start with one sample
// assumes the core samples meas on the rising clk edge; drives on the falling one
module fe_model (
   input  wire logic                          clk,
   input  wire logic                          meas_start,
   input  wire logic                          meas_channel,
   input  wire logic signed [11:0]            loc_q,
   input  wire logic signed [11:0]            rem_q,
   input  wire logic                          fault,
   input  wire logic                          dither,
   output temp_readout_pkg::meas_result_s     meas
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0]         cnt = 2'd0;
   logic               tog = 1'b0;
   logic signed [11:0] q;
   initial meas = '0;
   // dither alternates +2 degrees on remote samples so that averaging shows
   assign q = (meas_channel ? rem_q : loc_q) + ((dither && meas_channel && tog) ? 12'sd8 : 12'sd0);
   always @(negedge clk) begin
      meas.valid       <= (cnt == 2'd1);
      meas.diode_fault <= (cnt == 2'd1) && meas_channel && fault;
      // no stale sample between answers
      meas.quarter_deg <= (cnt == 2'd1) ? q : ~meas.quarter_deg;
      if (cnt == 2'd1 && meas_channel) tog <= ~tog;
      cnt <= meas_start ? 2'd3 : ((cnt != 2'd0) ? cnt - 2'd1 : 2'd0);
   end
endmodule // fe_model

// ===== testbench.sv
// self-checking bench: register link tasks, front end model, fixed sequence
// assumes the core runs with a short base conversion period of 50 cycles, 200 at the reset rate
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, srst = 1, link_clk = 0, link_srst = 1, req_valid = 0, ce = 1;
   logic fault = 0, dither = 0, prev = 0;
   logic meas_start, meas_channel, alarm_out_n, overtemp_out_n, req_ready, rsp_valid;
   logic [7:0] rsp_data, rdat;
   logic signed [11:0] loc_q = 12'sd103, rem_q = 12'sd201;
   logic [7:0] lim_rst [6] = '{8'h7f, 8'h00, 8'h7f, 8'h7f, 8'h00, 8'h7f};
   temp_readout_pkg::reg_req_s req = '0;
   temp_readout_pkg::meas_result_s meas;
   int n_errors = 0, n_checks = 0;
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #62.5 link_clk = ~link_clk;
   end
   temp_readout #(.FAST_PERIOD(50)) DUT (.clk(clk), .srst(srst), .ce(ce), .meas(meas),
      .meas_start(meas_start), .meas_channel(meas_channel), .alarm_out_n(alarm_out_n),
      .overtemp_out_n(overtemp_out_n), .link_clk(link_clk), .link_srst(link_srst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data));
   fe_model fe (.clk(clk), .meas_start(meas_start), .meas_channel(meas_channel),
      .loc_q(loc_q), .rem_q(rem_q), .fault(fault), .dither(dither), .meas(meas));
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic fail();
      n_errors++;
      $display("ERROR %0t wait ran out", $time);
      end_of_test();
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // ready and response are looked at on falling edges, where they stand settled;
   // the request is taken at the rising edge after ready is seen high
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(negedge link_clk);
      req_valid = 1;
      req = '{write: w, addr: a, data: d};
      for (i = 0; i <= 20 && req_ready !== 1'b1; i++)
         @(negedge link_clk);
      if (i > 20) fail();
      @(posedge link_clk);
      @(negedge link_clk);
      req_valid = 0;
      for (i = 0; !w && i <= 20; i++) begin
         @(negedge link_clk);
         if (rsp_valid === 1'b1) break;
      end
      if (i > 20) fail();
      rdat = rsp_data;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rdat, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   // two starts of a remote measurement enclose a full pair on fresh stimulus
   task automatic conv();
      int i, n;
      n = 0;
      for (i = 0; n < 2; i++) begin
         @(negedge clk);
         if (meas_channel === 1'b1 && prev === 1'b0) n++;
         prev = meas_channel;
         if (i > 20000) fail();
      end
      repeat (5) @(negedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk) srst = 0;
      @(negedge link_clk) link_srst = 0;
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h08);
      for (int k = 0; k < 6; k++) rd(8'h20 + 8'(k), lim_rst[k]);
      conv();
      rd(8'h00, 8'h19);
      rd(8'h01, 8'h32);
      rd(8'h10, 8'h40);
      rd(8'h3f, 8'h00);
      wr(8'h00, 8'h55);
      rd(8'h00, 8'h19);
      rd(8'h02, 8'h00);
      wr(8'h23, 8'h28);
      wr(8'h25, 8'h30);
      conv();
      rd(8'h02, 8'h12);
      chk({7'h0, alarm_out_n}, 8'h00);
      chk({7'h0, overtemp_out_n}, 8'h00);
      wr(8'h09, 8'h80);
      conv();
      chk({7'h0, alarm_out_n}, 8'h01);
      wr(8'h09, 8'ha0);
      conv();
      chk({7'h0, alarm_out_n}, 8'h00);
      wr(8'h23, 8'h7f);
      wr(8'h25, 8'h7f);
      wr(8'h09, 8'h00);
      loc_q = -12'sd40;
      rem_q = 12'sd522;
      conv();
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h7f);
      rd(8'h10, 8'h00);
      chk({7'h0, overtemp_out_n}, 8'h01);
      chk({7'h0, alarm_out_n}, 8'h01);
      wr(8'h09, 8'hff);
      rd(8'h03, 8'he4);
      wr(8'h09, 8'h04);
      loc_q = 12'sd0;
      rem_q = -12'sd220;
      conv();
      rd(8'h00, 8'h40);
      rd(8'h01, 8'h09);
      rd(8'h10, 8'h00);
      rd(8'h23, 8'h7f);
      rem_q = 12'sd767;
      conv();
      rd(8'h01, 8'hff);
      rd(8'h10, 8'hc0);
      wr(8'h09, 8'h00);
      rem_q = 12'sd201;
      conv();
      fault = 1;
      rem_q = 12'sd80;
      conv();
      rd(8'h01, 8'h32);
      rd(8'h02, 8'h04);
      chk({7'h0, alarm_out_n}, 8'h00);
      fault = 0;
      wr(8'h0a, 8'h07);
      rem_q = 12'sd200;
      dither = 1;
      conv();
      rd(8'h01, 8'h33);
      rd(8'h10, 8'h00);
      rd(8'h04, 8'h07);
      // standby: let the pair in flight finish, then a new local value must not land
      wr(8'h09, 8'h40);
      repeat (300) @(negedge clk);
      loc_q = 12'sd100;
      repeat (900) @(negedge clk);
      rd(8'h00, 8'h00);
      end_of_test();
   end
endmodule // testbench
